/* src/pmon_defs.svh */
// Offsets, field positions, reset values and timing counts of the power monitor back end
`ifndef PMON_DEFS_SVH
`define PMON_DEFS_SVH

// ********************************
// Register pointer offsets
// ********************************
`define REG_CONFIG 8'h00
`define REG_SHUNT 8'h01
`define REG_BUS 8'h02
`define REG_POWER 8'h03
`define REG_CURRENT 8'h04
`define REG_CALIB 8'h05
`define REG_ALERT_SEL 8'h06
`define REG_ALERT_LIMIT 8'h07

// ********************************
// Field positions
// ********************************
`define CFG_AVG_LSB 9
`define CFG_BUSCT_LSB 6
`define CFG_SHCT_LSB 3
`define CFG_MODE_LSB 0
`define MSK_FN_LSB 11
`define MSK_CONV_READY_ALERT_ENABLE_BIT 10
`define MSK_AFF_BIT 4
`define MSK_CONV_READY_FLAG_BIT 3
`define MSK_ALERT_POLARITY_BIT 1
`define MSK_LEN_BIT 0

// ********************************
// Reset values
// ********************************
`define CFG_RST_AVG 3'h0
`define CFG_RST_BUSCT 3'h4
`define CFG_RST_SHCT 3'h4
`define CFG_RST_MODE 3'h7
`define CFG_FIXED_RD 4'h4
`define CALIB_RST 16'h0000
`define LIMIT_RST 16'h0000

// ********************************
// Arithmetic scaling
// ********************************
`define CUR_SHIFT 11
`define PWR_DIVISOR 33'd20000

// ********************************
// Conversion times in microseconds
// ********************************
`define CLK_MHZ 40
`define CT0_US 140
`define CT1_US 204
`define CT2_US 332
`define CT3_US 588
`define CT4_US 1100
`define CT5_US 2116
`define CT6_US 4156
`define CT7_US 8244

`endif

/* src/pmon_pkg.sv */
// Types shared by the power monitor back end
package pmon_pkg;

    // Configuration fields
    typedef struct packed {
        logic [2:0] avg;
        logic [2:0] bus_ct;
        logic [2:0] sh_ct;
        logic [2:0] mode;
    } cfg_t;

    // Alert select and enable fields
    typedef struct packed {
        logic [4:0] fn_sel;
        logic conv_ready_alert_enable;
        logic alert_polarity;
        logic latch_en;
    } alert_cfg_t;

    // Measurement sequencer
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_SHUNT = 3'b010,
        SEQ_BUS = 3'b100
    } seq_state_t;

endpackage : pmon_pkg

/* src/power_monitor_average_alert.sv */
// Power monitor digital back end: sequencer, arithmetic, averaging, registers and alert pin
// Operation
// - Compute current right after each shunt measurement using calibration factor.
// - With calibration zero, stored current and power are zero.
// - Compute power after each bus measurement from bus and latest current.
// - Arithmetic runs alongside conversions, adding no conversion time.
// - Averaging above one adds results into accumulators, not output registers.
// - Shunt and bus accumulate too; averages load all measured outputs together.
// - Conversion times span 140 us shortest to 8.244 ms longest.
// - Shunt and bus times and averaging set independently; include 588 us, 4.156 ms.
// - Update period is shunt time plus bus time, times averaging count.
// - One shared threshold register at 07h compared against selected function.
// - Five functions: shunt over, shunt under, bus over, bus under, power over.
// - Open-drain alert asserts when selected quantity crosses threshold.
// - With several selects set, only the highest set bit counts.
// - Conversion-ready enable also drives alert beside the selected function.
// - With conversion-ready enable clear, alert follows threshold violations only.
// - Alert function flag, bit 4, sets on a violation of the selected function only.
// - Alert active level follows polarity bit 1 of alert select register.
// - With latching, flag and pin hold until config write or select read.
// - Shunt limits compared with measured shunt after every shunt conversion.
// - Bus limits compared with measured bus after every bus conversion.
// - Power limit compared with calculated power after every bus conversion.
// - Ready flag sets at completion; clears on non-power-down config write or select read.
// - Current equals shunt times calibration divided by 2048.
// - Power equals current times bus divided by 20000.
// - Mode 111 repeats shunt then bus conversions continuously.
`include "pmon_defs.svh"

module power_monitor_average_alert
    import pmon_pkg::*;
#(
    // Conversion lengths in sys_clk cycles, one per time code
    parameter int unsigned conv_cycles [8] = '{
        `CT0_US * `CLK_MHZ, `CT1_US * `CLK_MHZ, `CT2_US * `CLK_MHZ, `CT3_US * `CLK_MHZ,
        `CT4_US * `CLK_MHZ, `CT5_US * `CLK_MHZ, `CT6_US * `CLK_MHZ, `CT7_US * `CLK_MHZ
    }
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic [15:0] shunt_code,
    input wire logic [15:0] bus_code,
    output logic shunt_conv_active,
    output logic bus_conv_active,
    input wire logic alert_pin_in,
    output logic alert_pin_out,
    output logic alert_pin_oe_n
);

    // ********************************
    // State
    // ********************************
    cfg_t cfg_ff;
    alert_cfg_t acfg_ff;
    seq_state_t state_ff, nxt_state;
    logic [19:0] cnt_ff, nxt_cnt;
    logic [9:0] samp_cnt_ff;
    logic [15:0] calib_ff, limit_ff;
    logic [15:0] shunt_out_ff, bus_out_ff, cur_out_ff, pwr_out_ff;
    logic [15:0] cur_last_ff;
    logic signed [25:0] acc_shunt_ff, acc_cur_ff;
    logic [25:0] acc_bus_ff, acc_pwr_ff;
    logic aff_ff, conv_ready_flag_ff;
    logic drive_low_ff;

    // ********************************
    // Register access decode
    // ********************************
    wire cfg_wr = reg_wr && (reg_addr == `REG_CONFIG);
    wire cal_wr = reg_wr && (reg_addr == `REG_CALIB);
    wire sel_wr = reg_wr && (reg_addr == `REG_ALERT_SEL);
    wire lim_wr = reg_wr && (reg_addr == `REG_ALERT_LIMIT);
    wire sel_rd = reg_rd && (reg_addr == `REG_ALERT_SEL);
    wire [2:0] wr_mode = reg_wdata[`CFG_MODE_LSB +: 3];
    wire wr_active = (wr_mode != 3'h0) && (wr_mode != 3'h4);

    // Mode bits: bit 0 shunt, bit 1 bus, bit 2 continuous
    wire do_shunt = cfg_ff.mode[0];
    wire do_bus = cfg_ff.mode[1];
    wire continuous = cfg_ff.mode[2];
    wire [2:0] new_shunt_en = reg_wdata[`CFG_MODE_LSB +: 3];

    // ********************************
    // Conversion timing
    // ********************************
    // conversion length lookup
    wire [19:0] sh_len = 20'(conv_cycles[cfg_ff.sh_ct] - 1);
    wire [19:0] bus_len = 20'(conv_cycles[cfg_ff.bus_ct] - 1);
    wire [19:0] wr_sh_len = 20'(conv_cycles[reg_wdata[`CFG_SHCT_LSB +: 3]] - 1);
    wire [19:0] wr_bus_len = 20'(conv_cycles[reg_wdata[`CFG_BUSCT_LSB +: 3]] - 1);

    wire shunt_done = (state_ff == SEQ_SHUNT) && (cnt_ff == 20'h00000);
    wire bus_done = (state_ff == SEQ_BUS) && (cnt_ff == 20'h00000);
    wire sample_end = (shunt_done && !do_bus) || bus_done;

    // Averaging count as a shift, counts are all powers of two
    logic [3:0] avg_shift;
    always_comb begin
        unique case (cfg_ff.avg)
            3'h0: avg_shift = 4'h0;
            3'h1: avg_shift = 4'h2;
            3'h2: avg_shift = 4'h4;
            3'h3: avg_shift = 4'h6;
            3'h4: avg_shift = 4'h7;
            3'h5: avg_shift = 4'h8;
            3'h6: avg_shift = 4'h9;
            3'h7: avg_shift = 4'ha;
        endcase
    end
    wire [9:0] avg_last = 10'((11'h001 << avg_shift) - 11'h001);
    // one output per count of shunt plus bus periods
    wire last_sample = (samp_cnt_ff == avg_last);
    wire load_out = sample_end && last_sample;

    // ********************************
    // Arithmetic, computed in the cycle the sample lands
    // ********************************
    wire calib_zero = (calib_ff == 16'h0000);
    wire signed [32:0] cur_prod = $signed(shunt_code) * $signed({1'b0, calib_ff});
    // scale by the fixed divide of 2048
    wire signed [32:0] cur_scaled = cur_prod >>> `CUR_SHIFT;
    wire [15:0] cur_new = calib_zero ? 16'h0000 : cur_scaled[15:0];
    wire [15:0] cur_mag = cur_last_ff[15] ? 16'(-cur_last_ff) : cur_last_ff;
    // latest current times bus over 20000
    wire [32:0] pwr_prod = {1'b0, cur_mag} * {17'h00000, bus_code};
    wire [32:0] pwr_div = pwr_prod / `PWR_DIVISOR;
    wire [15:0] pwr_new = calib_zero ? 16'h0000 : pwr_div[15:0];

    // Sums include the sample landing this cycle so the last one is not missed
    wire signed [25:0] shunt_sum = acc_shunt_ff + (shunt_done ? 26'(signed'(shunt_code)) : 26'sh0);
    wire signed [25:0] cur_sum = acc_cur_ff + (shunt_done ? 26'(signed'(cur_new)) : 26'sh0);
    wire [25:0] bus_sum = acc_bus_ff + (bus_done ? {10'h000, bus_code} : 26'h0);
    wire [25:0] pwr_sum = acc_pwr_ff + (bus_done ? {10'h000, pwr_new} : 26'h0);
    // divide by count, truncate to register width
    wire signed [25:0] shunt_avg = shunt_sum >>> avg_shift;
    wire signed [25:0] cur_avg = cur_sum >>> avg_shift;
    wire [25:0] bus_avg = bus_sum >> avg_shift;
    wire [25:0] pwr_avg = pwr_sum >> avg_shift;

    // ********************************
    // Sequencer
    // ********************************
    // shunt then bus, repeated while continuous
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = (cnt_ff == 20'h00000) ? cnt_ff : 20'(cnt_ff - 20'h00001);
        if (cfg_wr) begin
            nxt_state = !wr_active ? SEQ_IDLE : (new_shunt_en[0] ? SEQ_SHUNT : SEQ_BUS);
            nxt_cnt = new_shunt_en[0] ? wr_sh_len : wr_bus_len;
        end else begin
            unique case (state_ff)
                SEQ_IDLE: begin
                    nxt_cnt = 20'h00000;
                end
                SEQ_SHUNT: begin
                    if (shunt_done && do_bus) begin
                        nxt_state = SEQ_BUS;
                        nxt_cnt = bus_len;
                    end
                end
                SEQ_BUS: begin
                    nxt_cnt = bus_done ? cnt_ff : nxt_cnt;
                end
            endcase
            if (sample_end) begin
                if (load_out && !continuous) begin
                    nxt_state = SEQ_IDLE;
                end else begin
                    nxt_state = do_shunt ? SEQ_SHUNT : SEQ_BUS;
                    nxt_cnt = do_shunt ? sh_len : bus_len;
                end
            end
        end
    end

    // Sequencer flops, power-on default is continuous shunt and bus
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= SEQ_SHUNT;
            cnt_ff <= 20'(conv_cycles[`CFG_RST_SHCT] - 1);
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Sample count, restarted by any config write
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            samp_cnt_ff <= 10'h000;
        end else if (cfg_wr || load_out) begin
            samp_cnt_ff <= 10'h000;
        end else if (sample_end) begin
            samp_cnt_ff <= 10'(samp_cnt_ff + 10'h001);
        end
    end

    // current taken at every shunt conversion end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur_last_ff <= 16'h0000;
        end else if (shunt_done) begin
            cur_last_ff <= cur_new;
        end
    end

    // running sums stay internal until the set completes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            acc_shunt_ff <= 26'sh0;
            acc_cur_ff <= 26'sh0;
            acc_bus_ff <= 26'h0;
            acc_pwr_ff <= 26'h0;
        end else if (cfg_wr || load_out) begin
            acc_shunt_ff <= 26'sh0;
            acc_cur_ff <= 26'sh0;
            acc_bus_ff <= 26'h0;
            acc_pwr_ff <= 26'h0;
        end else begin
            acc_shunt_ff <= shunt_sum;
            acc_cur_ff <= cur_sum;
            acc_bus_ff <= bus_sum;
            acc_pwr_ff <= pwr_sum;
        end
    end

    // averaged results load together; only measured channels change
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            shunt_out_ff <= 16'h0000;
            cur_out_ff <= 16'h0000;
            bus_out_ff <= 16'h0000;
            pwr_out_ff <= 16'h0000;
        end else if (load_out) begin
            shunt_out_ff <= do_shunt ? shunt_avg[15:0] : shunt_out_ff;
            cur_out_ff <= do_shunt ? cur_avg[15:0] : cur_out_ff;
            bus_out_ff <= do_bus ? bus_avg[15:0] : bus_out_ff;
            pwr_out_ff <= do_bus ? pwr_avg[15:0] : pwr_out_ff;
        end
    end

    // ********************************
    // Writable registers
    // ********************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_ff <= '{`CFG_RST_AVG, `CFG_RST_BUSCT, `CFG_RST_SHCT, `CFG_RST_MODE};
            acfg_ff <= '0;
            calib_ff <= `CALIB_RST;
            limit_ff <= `LIMIT_RST;
        end else begin
            if (cfg_wr) begin
                cfg_ff <= reg_wdata[11:0];
            end
            if (sel_wr) begin
                acfg_ff <= {reg_wdata[`MSK_FN_LSB +: 5], reg_wdata[`MSK_CONV_READY_ALERT_ENABLE_BIT],
                            reg_wdata[`MSK_ALERT_POLARITY_BIT], reg_wdata[`MSK_LEN_BIT]};
            end
            if (cal_wr) begin
                calib_ff <= reg_wdata;
            end
            if (lim_wr) begin
                limit_ff <= reg_wdata;
            end
        end
    end

    // ********************************
    // Alert compare
    // ********************************
    // highest set select bit wins
    wire [4:0] fn = acfg_ff.fn_sel;
    wire sel_sol = fn[4];
    wire sel_sul = !fn[4] && fn[3];
    wire sel_bol = fn[4:3] == 2'b00 && fn[2];
    wire sel_bul = fn[4:2] == 3'b000 && fn[1];
    wire sel_pol = fn[4:1] == 4'h0 && fn[0];
    // strictly above for over, strictly below for under
    wire sh_over = $signed(shunt_code) > $signed(limit_ff);
    wire sh_under = $signed(shunt_code) < $signed(limit_ff);
    wire bus_over = bus_code > limit_ff;
    wire bus_under = bus_code < limit_ff;
    wire pwr_over = pwr_new > limit_ff;
    wire sh_viol = shunt_done && ((sel_sol && sh_over) || (sel_sul && sh_under));
    wire bus_viol = bus_done && ((sel_bol && bus_over) || (sel_bul && bus_under) || (sel_pol && pwr_over));
    wire cmp_event = (shunt_done && (sel_sol || sel_sul)) || (bus_done && (sel_bol || sel_bul || sel_pol));
    wire viol = sh_viol || bus_viol;
    wire latch_clr = acfg_ff.latch_en && (cfg_wr || sel_rd);

    // flag sets on violation, set beats clear
    // latched flag holds until config write or select read
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aff_ff <= 1'b0;
        end else if (viol) begin
            aff_ff <= 1'b1;
        end else if ((cmp_event && !acfg_ff.latch_en) || latch_clr) begin
            aff_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            conv_ready_flag_ff <= 1'b0;
        end else if (load_out) begin
            conv_ready_flag_ff <= 1'b1;
        end else if ((cfg_wr && wr_active) || sel_rd) begin
            conv_ready_flag_ff <= 1'b0;
        end
    end

    // ********************************
    // Alert pin
    // ********************************
    // ready joins the function when enabled
    wire alert_active = aff_ff || (acfg_ff.conv_ready_alert_enable && conv_ready_flag_ff);
    // polarity picks which level is pulled
    // open drain: pulled low or released
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            drive_low_ff <= 1'b0;
        end else begin
            drive_low_ff <= alert_active ^ acfg_ff.alert_polarity;
        end
    end
    assign alert_pin_out = 1'b0;
    assign alert_pin_oe_n = !drive_low_ff;

    assign shunt_conv_active = (state_ff == SEQ_SHUNT);
    assign bus_conv_active = (state_ff == SEQ_BUS);

    // ********************************
    // Read path
    // ********************************
    // source bits exposed for the host to tell causes apart
    wire [15:0] sel_rd_val = {acfg_ff.fn_sel, acfg_ff.conv_ready_alert_enable, 5'h00,
                              aff_ff, conv_ready_flag_ff, 1'b0, acfg_ff.alert_polarity, acfg_ff.latch_en};
    logic [15:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            `REG_CONFIG: rd_mux = {`CFG_FIXED_RD, cfg_ff};
            `REG_SHUNT: rd_mux = shunt_out_ff;
            `REG_BUS: rd_mux = bus_out_ff;
            `REG_POWER: rd_mux = pwr_out_ff;
            `REG_CURRENT: rd_mux = cur_out_ff;
            `REG_CALIB: rd_mux = calib_ff;
            `REG_ALERT_SEL: rd_mux = sel_rd_val;
            `REG_ALERT_LIMIT: rd_mux = limit_ff;
            default: rd_mux = 16'h0000;
        endcase
    end

    // Read data held until the next read, unmapped reads zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

endmodule : power_monitor_average_alert

/* sim/pmon_front_model.sv */
// Behavioural converter outputs and the pulled-up alert wire
module pmon_front_model (
    input wire logic shunt_conv_active,
    input wire logic bus_conv_active,
    input wire logic [15:0] sh_val,
    input wire logic [15:0] bu_val,
    input wire logic [15:0] step,
    input wire logic alert_pin_out,
    input wire logic alert_pin_oe_n,
    output logic [15:0] shunt_code,
    output logic [15:0] bus_code,
    output logic alert_line
);
    timeunit 1ns;
    timeprecision 100ps;
    logic odd_ff = 1'b0;
    // Every other shunt sample gets the step, so averaging is exercised
    always @(posedge shunt_conv_active) odd_ff <= ~odd_ff;
    // Codes are inverted outside a conversion so a stale sample shows up
    assign shunt_code = shunt_conv_active ? sh_val + (odd_ff ? step : 16'h0000) : ~sh_val;
    assign bus_code = bus_conv_active ? bu_val : ~bu_val;
    assign alert_line = alert_pin_oe_n ? 1'b1 : alert_pin_out;
endmodule : pmon_front_model

/* sim/pmon_chk.sv */
// Port-level assertions for the power monitor back end
module pmon_chk
    import pmon_pkg::*;
#(
    parameter int unsigned conv_cycles [8] = '{4, 4, 4, 4, 4, 4, 4, 4}
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic shunt_conv_active,
    input wire logic bus_conv_active,
    input wire logic alert_pin_out,
    input wire logic alert_pin_oe_n
);
    logic [11:0] cfg_ff;
    logic [15:0] cal_ff, lim_ff, sh_cnt_ff, bu_cnt_ff;
    logic cal_set_ff, ok_ff;
    logic [1:0] act_ff;
    wire cfg_wr = reg_wr && reg_addr == 8'h00;
    wire any_act = shunt_conv_active | bus_conv_active;
    wire ev = reg_wr | reg_rd | (act_ff != {shunt_conv_active, bus_conv_active});
    // Shadow copies of writable registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_ff <= 12'h127;
            cal_ff <= 16'h0000;
            lim_ff <= 16'h0000;
            cal_set_ff <= 1'b0;
        end else begin
            if (cfg_wr) cfg_ff <= reg_wdata[11:0];
            if (reg_wr && reg_addr == 8'h05) cal_ff <= reg_wdata;
            if (reg_wr && reg_addr == 8'h05 && reg_wdata != 16'h0000) cal_set_ff <= 1'b1;
            if (reg_wr && reg_addr == 8'h07) lim_ff <= reg_wdata;
        end
    end
    // Run lengths; a run cut short by a config write is not judged
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sh_cnt_ff <= 16'h0000;
            bu_cnt_ff <= 16'h0000;
            act_ff <= 2'h2;
            ok_ff <= 1'b0;
        end else begin
            sh_cnt_ff <= shunt_conv_active ? sh_cnt_ff + 16'h0001 : 16'h0000;
            bu_cnt_ff <= bus_conv_active ? bu_cnt_ff + 16'h0001 : 16'h0000;
            act_ff <= {shunt_conv_active, bus_conv_active};
            ok_ff <= (cfg_wr && any_act) ? 1'b0 : (!any_act ? 1'b1 : ok_ff);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence rd_at(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    chk_pin_data_low: assert property (alert_pin_out == 1'b0)
        else $error("alert data not low");
    chk_one_channel: assert property (!(shunt_conv_active && bus_conv_active))
        else $error("both channels converting");
    chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > 8'h07 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_config_read: assert property (rd_at(8'h00) |=> reg_rdata == {4'h4, cfg_ff})
        else $error("config readback wrong");
    chk_limit_read: assert property (rd_at(8'h07) |=> reg_rdata == lim_ff)
        else $error("limit readback wrong");
    chk_calib_read: assert property (rd_at(8'h05) |=> reg_rdata == cal_ff)
        else $error("calibration readback wrong");
    chk_no_cal_zero: assert property ((rd_at(8'h03) or rd_at(8'h04)) ##0 !cal_set_ff |=> reg_rdata == 16'h0000)
        else $error("current or power nonzero without calibration");
    chk_shunt_len: assert property ($fell(shunt_conv_active) && ok_ff |-> sh_cnt_ff == conv_cycles[cfg_ff[5:3]])
        else $error("shunt conversion length wrong");
    chk_bus_len: assert property ($fell(bus_conv_active) && ok_ff |-> bu_cnt_ff == conv_cycles[cfg_ff[8:6]])
        else $error("bus conversion length wrong");
    chk_pin_cause: assert property ($changed(alert_pin_oe_n) |-> $past(ev, 1) || $past(ev, 2) || $past(ev, 3))
        else $error("alert pin moved without a cause");
endmodule : pmon_chk

bind power_monitor_average_alert pmon_chk #(.conv_cycles(conv_cycles)) u_chk (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .shunt_conv_active(shunt_conv_active), .bus_conv_active(bus_conv_active), .alert_pin_out(alert_pin_out),
    .alert_pin_oe_n(alert_pin_oe_n));

/* sim/tb_power_monitor_average_alert.sv */
// Self-checking bench for the power monitor back end
module tb_power_monitor_average_alert;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] sh_val = 16'h03e8;
    logic [15:0] bu_val = 16'h4e20;
    logic [15:0] step = 16'h0000;
    logic [15:0] reg_rdata, shunt_code, bus_code, rv;
    logic shunt_conv_active, bus_conv_active, alert_pin_out, alert_pin_oe_n, alert_line;
    int err_total = 0;
    int n_tests = 0;
    int i, n;
    // Alert cases: select word, limit, expected flag (bit i)
    logic [15:0] msk [11] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0800,
        16'hc000, 16'h1800, 16'h8000, 16'h8002, 16'h4002};
    logic [15:0] lim [11] = '{16'h01f4, 16'h01f4, 16'h7530, 16'h7530, 16'h0384, 16'h7530,
        16'h01f4, 16'h7530, 16'h03e8, 16'h01f4, 16'h01f4};
    logic [10:0] aff = 11'h2d9;
    always #12.5 sys_clk = ~sys_clk;
    power_monitor_average_alert #(.conv_cycles('{4, 5, 6, 7, 8, 9, 10, 11})) uut (.sys_clk(sys_clk),
        .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .shunt_code(shunt_code), .bus_code(bus_code),
        .shunt_conv_active(shunt_conv_active), .bus_conv_active(bus_conv_active),
        .alert_pin_in(alert_line), .alert_pin_out(alert_pin_out), .alert_pin_oe_n(alert_pin_oe_n));
    pmon_front_model front (.shunt_conv_active(shunt_conv_active), .bus_conv_active(bus_conv_active),
        .sh_val(sh_val), .bu_val(bu_val), .step(step), .alert_pin_out(alert_pin_out),
        .alert_pin_oe_n(alert_pin_oe_n), .shunt_code(shunt_code), .bus_code(bus_code), .alert_line(alert_line));
    // ****************************************
    // Access tasks
    // ****************************************
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One idle cycle between accesses keeps each strobe a clean pulse
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #2 reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        #2;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #2 reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [15:0] e, input string nm);
        rd(a, rv);
        chk(nm, rv, e);
    endtask : rc
    // Count busy cycles until the set finishes, bounded, then let flags settle
    task automatic fin(output int c);
        int k;
        c = 0;
        for (k = 0; k < 3000 && !(c > 0 && !(shunt_conv_active | bus_conv_active)); k++) begin
            if (shunt_conv_active | bus_conv_active) c++;
            @(posedge sys_clk);
            #2;
        end
        repeat (3) @(posedge sys_clk);
        #2;
    endtask : fin
    task automatic results();
        $display("compares %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (8) @(posedge sys_clk);
        #2 rstn = 1'b1;
        chk("pin idle", {15'h0000, alert_line}, 16'h0001);
        rc(8'h00, 16'h4127, "config");
        rc(8'h07, 16'h0000, "limit");
        rc(8'h09, 16'h0000, "unmapped");
        repeat (40) @(posedge sys_clk);
        rc(8'h04, 16'h0000, "current no cal");
        rc(8'h03, 16'h0000, "power no cal");
        rc(8'h01, 16'h03e8, "shunt cont");
        wr(8'h00, 16'h0000);
        sh_val = 16'h3e80;
        bu_val = 16'h2560;
        wr(8'h05, 16'h0a00);
        wr(8'h00, 16'h0043);
        fin(n);
        chk("set length", n[15:0], 16'h0009);
        rc(8'h01, 16'h3e80, "shunt");
        rc(8'h02, 16'h2560, "bus");
        rc(8'h04, 16'h4e20, "current");
        rc(8'h03, 16'h2560, "power");
        rd(8'h06, rv);
        chk("ready set", {15'h0000, rv[3]}, 16'h0001);
        rd(8'h06, rv);
        chk("ready cleared", {15'h0000, rv[3]}, 16'h0000);
        sh_val = 16'h03e8;
        bu_val = 16'h4e20;
        step = 16'h0002;
        wr(8'h05, 16'h0800);
        wr(8'h00, 16'h0203);
        fork
            fin(n);
            begin
                repeat (10) @(posedge sys_clk);
                rc(8'h04, 16'h4e20, "current held");
            end
        join
        chk("avg length", n[15:0], 16'h0020);
        rc(8'h01, 16'h03e9, "shunt avg");
        rc(8'h02, 16'h4e20, "bus avg");
        rc(8'h04, 16'h03e9, "current avg");
        rc(8'h03, 16'h03e9, "power avg");
        step = 16'h0000;
        for (i = 0; i < 11; i++) begin
            wr(8'h07, lim[i]);
            wr(8'h06, msk[i]);
            wr(8'h00, 16'h0003);
            fin(n);
            chk("alert pin", {15'h0000, alert_line}, {15'h0000, ~(aff[i] ^ msk[i][1])});
            rd(8'h06, rv);
            chk("alert flag", {15'h0000, rv[4]}, {15'h0000, aff[i]});
        end
        wr(8'h07, 16'h01f4);
        wr(8'h06, 16'h8001);
        wr(8'h00, 16'h0007);
        repeat (20) @(posedge sys_clk);
        sh_val = 16'h0000;
        repeat (30) @(posedge sys_clk);
        chk("latched pin", {15'h0000, alert_line}, 16'h0000);
        rd(8'h06, rv);
        chk("latched flag", {15'h0000, rv[4]}, 16'h0001);
        repeat (3) @(posedge sys_clk);
        chk("pin released", {15'h0000, alert_line}, 16'h0001);
        wr(8'h00, 16'h0000);
        wr(8'h06, 16'h0400);
        wr(8'h00, 16'h0003);
        fin(n);
        chk("ready pin", {15'h0000, alert_line}, 16'h0000);
        rd(8'h06, rv);
        chk("ready source", {15'h0000, rv[3]}, 16'h0001);
        repeat (3) @(posedge sys_clk);
        chk("ready pin off", {15'h0000, alert_line}, 16'h0001);
        results();
    end
    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        #200000;
        err_total++;
        results();
    end
endmodule : tb_power_monitor_average_alert
